// *** verilog/ioxp_target.v ***
// Target front end: strap decode, general call software reset and identity read
`timescale 1ns/1ps
`include "ioxp_defines.vh"

module ioxp_target (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus pins (open drain data)
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // Address straps
  input wire addr_strap_high_i,
  input wire addr_strap_mid_i,
  input wire addr_strap_low_i,
  // Device side
  output wire soft_rst_o,
  output wire [6:0] own_addr_o
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX = 6'h02;
  localparam [5:0] ST_DEC = 6'h04;
  localparam [5:0] ST_ACK = 6'h08;
  localparam [5:0] ST_TX = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Bus edge and condition detection

  reg scl_q_ff;
  reg sda_q_ff;
  wire scl_rise = scl_i & ~scl_q_ff;
  wire scl_fall = ~scl_i & scl_q_ff;
  wire bus_start = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  wire bus_stop = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap classification

  wire [2:0] strap_pin = {addr_strap_high_i, addr_strap_mid_i, addr_strap_low_i};
  wire [5:0] strap_code;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap
      reg seen_hi_ff;
      reg seen_lo_ff;
      reg diff_scl_ff;
      // Sticky history of the pin against both levels and the clock line
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          seen_hi_ff <= 1'b0;
          seen_lo_ff <= 1'b0;
          diff_scl_ff <= 1'b0;
        end else begin
          seen_hi_ff <= seen_hi_ff | strap_pin[gi];
          seen_lo_ff <= seen_lo_ff | ~strap_pin[gi];
          diff_scl_ff <= diff_scl_ff | (strap_pin[gi] ^ scl_i);
        end
      end
      // Never high: low; never low: high; tracks clock: SCL; otherwise SDA
      assign strap_code[2*gi+1:2*gi] = !seen_hi_ff ? `IOXP_STRAP_LOW :
                                       !seen_lo_ff ? `IOXP_STRAP_HIGH :
                                       !diff_scl_ff ? `IOXP_STRAP_SCL :
                                       `IOXP_STRAP_SDA;
    end
  endgenerate

  wire [2:0] strap_dyn = {strap_code[5], strap_code[3], strap_code[1]};
  wire [2:0] strap_val = {strap_code[4], strap_code[2], strap_code[0]};
  reg [3:0] addr_hi;

  always @* begin
    case (strap_dyn)
      3'h0: addr_hi = `IOXP_HI_SSS;
      3'h1: addr_hi = `IOXP_HI_SSD;
      3'h2: addr_hi = `IOXP_HI_SDS;
      3'h3: addr_hi = `IOXP_HI_SDD;
      3'h4: addr_hi = `IOXP_HI_DSS;
      3'h5: addr_hi = `IOXP_HI_DSD;
      3'h6: addr_hi = `IOXP_HI_DDS;
      default: addr_hi = `IOXP_HI_DDD;
    endcase
  end

  wire [6:0] own_addr = {addr_hi, strap_val};

  ////////////////////////////////////////////////////////////////////////////
  // Identity word

  wire [23:0] id_word = {`IOXP_ID_MFR, `IOXP_ID_PART, `IOXP_ID_REV};
  reg [1:0] id_idx_ff;
  reg [7:0] id_byte;

  always @* begin
    case (id_idx_ff)
      2'h0: id_byte = id_word[23:16];
      2'h1: id_byte = id_word[15:8];
      default: id_byte = id_word[7:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte decision

  reg [5:0] state_ff;
  reg [2:0] bit_cnt_ff;
  reg [6:0] rx_sh_ff;
  reg [7:0] tx_sh_ff;
  reg first_ff;
  reg data_cnt_ff;
  reg mode_gc_ff;
  reg mode_idw_ff;
  reg mode_own_ff;
  reg rd_ff;
  reg rd_id_ff;
  reg armed_ff;
  reg gc_ok_ff;
  reg ack_ff;
  reg sda_oe_ff;
  reg sda_ff;
  reg soft_rst_ff;
  reg [6:0] own_addr_ff;

  wire [7:0] rx_byte = {rx_sh_ff, sda_i};
  wire is_gc = rx_byte == `IOXP_GC_BYTE;
  wire is_idw = rx_byte == {`IOXP_ID_ADDR, 1'b0};
  wire is_idr = rx_byte == {`IOXP_ID_ADDR, 1'b1};
  wire is_own = rx_byte[7:1] == own_addr;
  wire byte_done = (state_ff == ST_RX) & scl_rise & (bit_cnt_ff == 3'h7);
  wire [7:0] tx_load = rd_id_ff ? id_byte : `IOXP_READ_FILL;

  ////////////////////////////////////////////////////////////////////////////
  // Target state machine

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 7'h00;
      tx_sh_ff <= 8'hFF;
      first_ff <= 1'b0;
      data_cnt_ff <= 1'b0;
      mode_gc_ff <= 1'b0;
      mode_idw_ff <= 1'b0;
      mode_own_ff <= 1'b0;
      rd_ff <= 1'b0;
      rd_id_ff <= 1'b0;
      armed_ff <= 1'b0;
      gc_ok_ff <= 1'b0;
      ack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_ff <= 1'b0;
      soft_rst_ff <= 1'b0;
      id_idx_ff <= 2'h0;
      own_addr_ff <= 7'h00;
    end else begin
      own_addr_ff <= own_addr;
      soft_rst_ff <= bus_stop & gc_ok_ff;
      if (bus_stop) begin
        // Stop ends everything, including a pending identity read
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
        gc_ok_ff <= 1'b0;
        armed_ff <= 1'b0;
        mode_gc_ff <= 1'b0;
        mode_idw_ff <= 1'b0;
        mode_own_ff <= 1'b0;
        rd_ff <= 1'b0;
        rd_id_ff <= 1'b0;
      end else if (bus_start) begin
        // Repeated start keeps the identity arming but voids a reset
        state_ff <= ST_RX;
        bit_cnt_ff <= 3'h0;
        first_ff <= 1'b1;
        data_cnt_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
        gc_ok_ff <= 1'b0;
        mode_gc_ff <= 1'b0;
        mode_idw_ff <= 1'b0;
        mode_own_ff <= 1'b0;
        rd_ff <= 1'b0;
        rd_id_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            sda_oe_ff <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              rx_sh_ff <= rx_byte[6:0];
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (byte_done) begin
              state_ff <= ST_DEC;
              ack_ff <= 1'b0;
              if (first_ff) begin
                first_ff <= 1'b0;
                armed_ff <= 1'b0;
                if (is_gc) begin
                  ack_ff <= 1'b1;
                  mode_gc_ff <= 1'b1;
                end else if (is_idw) begin
                  ack_ff <= 1'b1;
                  mode_idw_ff <= 1'b1;
                end else if (is_idr & armed_ff) begin
                  ack_ff <= 1'b1;
                  rd_ff <= 1'b1;
                  rd_id_ff <= 1'b1;
                  id_idx_ff <= 2'h0;
                end else if (is_own) begin
                  ack_ff <= 1'b1;
                  mode_own_ff <= 1'b1;
                  rd_ff <= rx_byte[0];
                end
              end else begin
                data_cnt_ff <= 1'b1;
                if (mode_gc_ff) begin
                  // Only a single 06h is accepted; any refusal voids the reset
                  ack_ff <= ~data_cnt_ff & (rx_byte == `IOXP_RESET_BYTE);
                  gc_ok_ff <= ~data_cnt_ff & (rx_byte == `IOXP_RESET_BYTE);
                end else if (mode_idw_ff) begin
                  ack_ff <= ~data_cnt_ff & is_own;
                  armed_ff <= ~data_cnt_ff & is_own;
                end else if (mode_own_ff) begin
                  ack_ff <= 1'b1;
                end
              end
            end
          end
          ST_DEC: begin
            if (scl_fall) begin
              state_ff <= ST_ACK;
              sda_oe_ff <= ack_ff;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_ff <= 3'h0;
              if (ack_ff & rd_ff) begin
                state_ff <= ST_TX;
                tx_sh_ff <= tx_load;
                sda_oe_ff <= ~tx_load[7];
              end else if (ack_ff) begin
                state_ff <= ST_RX;
                sda_oe_ff <= 1'b0;
              end else begin
                state_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_ff == 3'h7) begin
                state_ff <= ST_RACK;
                sda_oe_ff <= 1'b0;
                if (rd_id_ff) begin
                  id_idx_ff <= (id_idx_ff == 2'h2) ? 2'h0 : id_idx_ff + 2'h1;
                end
              end else begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
                sda_oe_ff <= ~tx_sh_ff[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise & sda_i) begin
              state_ff <= ST_IDLE;
              rd_ff <= 1'b0;
              rd_id_ff <= 1'b0;
            end else if (scl_fall) begin
              // Index stepped at the end of the byte, so the load is already current
              state_ff <= ST_TX;
              bit_cnt_ff <= 3'h0;
              tx_sh_ff <= tx_load;
              sda_oe_ff <= ~tx_load[7];
            end
          end
          default: begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o = sda_ff;
  assign sda_oe_o = sda_oe_ff;
  assign soft_rst_o = soft_rst_ff;
  assign own_addr_o = own_addr_ff;

endmodule

// *** pkg/ioxp_defines.vh ***
// Constants for the expander target front end: addresses, strap codes, identity fields
// Contract
// - Dynamic high strap maps to addresses 50h-67h and 70h-77h
// - Acknowledge general call write, refuse read
// - After general call, accept only 06h
// - Refuse every general call byte after first
// - STOP after accepted reset byte resets
// - Repeated START instead cancels the reset
// - Refused reset sequence changes nothing
// - Fixed 24-bit identity: 12/9/3 fields
// - Only matching target accepts address byte
// - STOP then START drops pending identity read
// - Other address after restart drops identity
// - Identity shifts out manufacturer, part, revision
// - Master refusal ends identity read, idle
// - Keep acknowledging wraps to first byte
// - Each strap decodes to four states
// - Last bit of first byte selects direction
`ifndef IOXP_DEFINES_VH
`define IOXP_DEFINES_VH

// Reserved bus bytes
`define IOXP_GC_BYTE 8'h00
`define IOXP_RESET_BYTE 8'h06
`define IOXP_ID_ADDR 7'h7C
`define IOXP_READ_FILL 8'hFF

// Strap state codes: bit 1 marks a bus-tied pin, bit 0 the high/SDA value
`define IOXP_STRAP_LOW 2'h0
`define IOXP_STRAP_HIGH 2'h1
`define IOXP_STRAP_SCL 2'h2
`define IOXP_STRAP_SDA 2'h3

// Upper address nibble by bus-tied pattern {high, mid, low}
`define IOXP_HI_SSS 4'h4
`define IOXP_HI_SSD 4'h5
`define IOXP_HI_SDS 4'h2
`define IOXP_HI_SDD 4'h3
`define IOXP_HI_DSS 4'hC
`define IOXP_HI_DSD 4'hE
`define IOXP_HI_DDS 4'hA
`define IOXP_HI_DDD 4'hB

// Identity fields; values are arbitrary
`define IOXP_ID_MFR 12'h5A5
`define IOXP_ID_PART 9'h0C3
`define IOXP_ID_REV 3'h1

`endif

// *** tb/ioxp_target_asserts.sv ***
// Port checker for the expander target front end
`timescale 1ns/1ps
module ioxp_target_asserts (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus and device side
  input wire scl_i,
  input wire sda_i,
  input wire sda_oe_o,
  input wire soft_rst_o,
  input wire [6:0] own_addr_o
);
  logic scl_ff, sda_ff, gc_ff;
  logic [3:0] cnt_ff;
  logic [2:0] nb_ff, ss_ff;
  logic [7:0] sh_ff;
  wire st = scl_ff & scl_i & sda_ff & ~sda_i;
  wire sp = scl_ff & scl_i & ~sda_ff & sda_i;
  wire rise = scl_i & ~scl_ff;
  wire ack = rise & (cnt_ff == 4'h8);
  // Bit, byte and stop-age tracking in the same sampling as the target
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      gc_ff <= 1'b0;
      cnt_ff <= 4'h0;
      nb_ff <= 3'h0;
      ss_ff <= 3'h7;
      sh_ff <= 8'h00;
    end else begin
      scl_ff <= scl_i;
      sda_ff <= sda_i;
      ss_ff <= sp ? 3'h0 : ss_ff + {2'h0, ss_ff != 3'h7};
      if (st) begin
        cnt_ff <= 4'h0;
        nb_ff <= 3'h0;
      end else if (rise) begin
        cnt_ff <= ack ? 4'h0 : cnt_ff + 4'h1;
        if (!ack) sh_ff <= {sh_ff[6:0], sda_i};
        if (ack && nb_ff != 3'h7) nb_ff <= nb_ff + 3'h1;
        if (ack && nb_ff == 3'h0) gc_ff <= (sh_ff == 8'h00) && sda_oe_o;
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_gc_wr_ack: assert property (
    ack && nb_ff == 3'h0 && sh_ff == 8'h00 |-> sda_oe_o) else $error("gc write refused");
  chk_gc_rd_nack: assert property (
    ack && nb_ff == 3'h0 && sh_ff == 8'h01 |-> !sda_oe_o) else $error("gc read taken");
  chk_gc_byte_nack: assert property (
    ack && nb_ff == 3'h1 && gc_ff && sh_ff != 8'h06 |-> !sda_oe_o) else $error("bad gc byte taken");
  chk_gc_extra_nack: assert property (
    ack && nb_ff > 3'h1 && gc_ff |-> !sda_oe_o) else $error("extra gc byte taken");
  chk_own_addr_ack: assert property (
    ack && nb_ff == 3'h0 && own_addr_o != 7'h00 && sh_ff[7:1] == own_addr_o |-> sda_oe_o)
    else $error("own address refused");
  chk_pulse_single: assert property (
    soft_rst_o |=> !soft_rst_o) else $error("reset pulse too long");
  chk_pulse_after_stop: assert property (
    soft_rst_o |-> ss_ff <= 3'h3) else $error("reset pulse without stop");
  chk_addr_in_map: assert property (
    own_addr_o != 7'h00 |-> own_addr_o inside {[7'h10:7'h2F], [7'h50:7'h67], [7'h70:7'h77]})
    else $error("own address off map");
  chk_sda_still_high: assert property (
    scl_i && scl_ff |-> $stable(sda_oe_o)) else $error("sda moved while scl high");
endmodule
bind ioxp_target ioxp_target_asserts chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_oe_o(sda_oe_o),
  .soft_rst_o(soft_rst_o),
  .own_addr_o(own_addr_o)
);

// *** tb/ioxp_master_model.sv ***
// Bus master model driving the clock and open-drain data toward the target
`timescale 1ns/1ps
module ioxp_master_model (
  // Clock
  input wire clk_i,
  // Bus
  input wire sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Start or repeated start; the line is left released first
  task automatic start;
    sda_low_o = 1'b0;
    tk(2);
    scl_o = 1'b1;
    tk(3);
    sda_low_o = 1'b1;
    tk(3);
    scl_o = 1'b0;
    tk(2);
  endtask
  task automatic stop;
    sda_low_o = 1'b1;
    tk(2);
    scl_o = 1'b1;
    tk(3);
    sda_low_o = 1'b0;
    tk(6);
  endtask
  task automatic send_bit(input logic b, output logic r);
    sda_low_o = !b;
    tk(3);
    scl_o = 1'b1;
    tk(3);
    r = sda_i;
    scl_o = 1'b0;
    tk(1);
  endtask
  // Last bit of an address byte is the direction
  task automatic wr(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(d[i], r);
    send_bit(1'b1, r);
    a = !r;
  endtask
  // Refusing the last byte ends an identity read
  task automatic rd(input logic a, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(1'b1, d[i]);
    send_bit(!a, r);
  endtask
endmodule

// *** tb/test_i2c_expander_addr_reset_id.sv ***
// Self-checking bench for the expander target front end
`timescale 1ns/1ps
`include "ioxp_defines.vh"
module test_i2c_expander_addr_reset_id;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire scl_w, sda_w, sda_o, sda_oe_o, soft_rst_o, m_low;
  wire [6:0] own_addr_o;
  int mismatches = 0;
  int checked = 0;
  int pulses = 0;
  logic a;
  logic [7:0] d;
  logic [23:0] id = {`IOXP_ID_MFR, `IOXP_ID_PART, `IOXP_ID_REV};
  `define CMP(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
  // Open-drain data line with pull-up
  assign sda_w = !(m_low || (sda_oe_o && !sda_o));
  ioxp_target dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_w),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .addr_strap_high_i(scl_w),
    .addr_strap_mid_i(sda_w),
    .addr_strap_low_i(1'b0),
    .soft_rst_o(soft_rst_o),
    .own_addr_o(own_addr_o)
  );
  ioxp_master_model mst (
    .clk_i(clk_i),
    .sda_i(sda_w),
    .scl_o(scl_w),
    .sda_low_o(m_low)
  );
  initial begin
    forever #50 clk_i = !clk_i;
  end
  always @(posedge clk_i) if (soft_rst_o === 1'b1) pulses++;
  task give_verdict;
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wra(input logic [7:0] b, input logic e);
    mst.wr(b, a);
    `CMP("ack", e, a)
  endtask
  task automatic t_gc_refuse;
    int p;
    p = pulses;
    mst.start();
    wra(8'h01, 1'b0);
    mst.stop();
    mst.start();
    wra(8'h00, 1'b1);
    wra(8'h07, 1'b0);
    mst.stop();
    `CMP("pulse", p, pulses)
    mst.start();
    wra(8'h00, 1'b1);
    wra(8'h06, 1'b1);
    wra(8'h06, 1'b0);
    mst.stop();
  endtask
  task automatic t_addr;
    mst.start();
    wra(8'hA4, 1'b1);
    wra(8'h3C, 1'b1);
    mst.stop();
    `CMP("own", 7'h52, own_addr_o)
    mst.start();
    wra(8'hA5, 1'b1);
    mst.rd(1'b0, d);
    `CMP("fill", 8'hFF, d)
    `CMP("drive", 1'b0, sda_o)
    mst.stop();
    mst.start();
    wra(8'hA6, 1'b0);
    mst.stop();
  endtask
  task automatic t_gc_reset(input logic rs);
    int p;
    p = pulses;
    mst.start();
    wra(8'h00, 1'b1);
    wra(8'h06, 1'b1);
    if (rs) mst.start();
    if (rs) wra(8'hA4, 1'b1);
    mst.stop();
    `CMP("pulse", p + (rs ? 0 : 1), pulses)
    mst.start();
    wra(8'hA4, 1'b1);
    mst.stop();
  endtask
  task automatic t_id;
    mst.start();
    wra(8'hF8, 1'b1);
    wra(8'hA5, 1'b1);
    mst.start();
    wra(8'hF9, 1'b1);
    for (int i = 0; i < 4; i++) begin
      mst.rd(i < 3, d);
      `CMP("id", id[23 - 8 * (i % 3) -: 8], d)
    end
    mst.stop();
    mst.start();
    wra(8'hF9, 1'b0);
    mst.stop();
  endtask
  task automatic t_id_drop;
    mst.start();
    wra(8'hF8, 1'b1);
    wra(8'hA6, 1'b0);
    mst.stop();
    mst.start();
    wra(8'hF8, 1'b1);
    wra(8'hA4, 1'b1);
    mst.stop();
    mst.start();
    wra(8'hF9, 1'b0);
    mst.stop();
    mst.start();
    wra(8'hF8, 1'b1);
    wra(8'hA4, 1'b1);
    mst.start();
    wra(8'h40, 1'b0);
    mst.start();
    wra(8'hF9, 1'b0);
    mst.stop();
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    t_gc_refuse();
    t_addr();
    t_gc_reset(1'b0);
    t_gc_reset(1'b1);
    t_id();
    t_id_drop();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule
